// file: hdl/pgc_defines.vh
// Function
// R01 - at system reset take the three power class straps as the advertised power class
// R02 - a later write to the power class field replaces the strapped default
// R03 - codes 000 to 011 are non-bus-powered classes: none, 15, 30, 45 W
// R04 - codes 100, 110, 111 are bus-powered classes; code 101 is reserved
// R05 - writing 1 to the bus reset request bit starts a bus reset
// R06 - a write setting the request bit also loads root holdoff and gap count
// R07 - sent and received config packets load root holdoff and gap count; the code drops one that meets a request-bit write
// R08 - two bus resets without a gap count update force the gap count to 63
// R09 - a register-initiated bus reset keeps the gap count just written
// R10 - after sending a config packet software must reset with matching values
// R11 - other register resets must write gap count 63 and current root holdoff
// R12 - software writes register 1 only with the request bit set
// R13 - straps are sampled once as reset releases, then ignored
`ifndef PGC_DEFINES_VH
`define PGC_DEFINES_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PGC_ADDR_BUSCTL   4'h0
`define PGC_ADDR_PWR      4'h4
`define PGC_ADDR_STATUS   4'h8
// ----------------------------------------------------------------
// bus control register fields
// ----------------------------------------------------------------
`define PGC_GAP_LSB       0
`define PGC_GAP_MSB       5
`define PGC_RHB_BIT       6
`define PGC_IBR_BIT       7
`define PGC_GAP_MAX       6'h3F
`define PGC_GAP_RESET     6'h3F
// ----------------------------------------------------------------
// power class register and self-id field
// ----------------------------------------------------------------
`define PGC_PWR_LSB       0
`define PGC_PWR_MSB       2
`define PGC_PWR_RESERVED  3'h5
`define PGC_SID_PWR_LSB   21
`define PGC_SID_PWR_MSB   23
// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define PGC_ST_ARMED_BIT  0
`define PGC_ST_BUSPWR_BIT 1
`define PGC_ST_RSVD_BIT   2
// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define PGC_RESP_OKAY     2'h0
`define PGC_RESP_SLVERR   2'h2
`endif

// file: hdl/pgc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "pgc_defines.vh"
module pgc_ctrl (
	input  wire        clock_i,
	input  wire        rst_n_i,
	input  wire [2:0]  power_class_straps_i,
	input  wire        bus_reset_done_i,
	input  wire        cfg_pkt_valid_i,
	input  wire        cfg_pkt_rhb_i,
	input  wire [5:0]  cfg_pkt_gap_i,
	input  wire [3:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [3:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	output reg         bus_reset_req_o,
	output reg  [5:0]  gap_count_o,
	output reg         root_holdoff_bit_o,
	output reg  [2:0]  power_class_o,
	output reg  [31:0] self_id_pwr_mask_o
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg        strap_pending;
reg        gap_armed;
reg        aw_held;
reg        w_held;
reg [3:0]  aw_addr;
reg [31:0] w_data;
reg [3:0]  w_strb;
wire       wr_fire;
wire       wr_busctl;
wire       wr_pwr;
wire       ibr_write;
reg [31:0] next_rdata;
reg [1:0]  next_rresp;

function is_mapped;
	input [3:0] a;
	begin
		is_mapped = (a == `PGC_ADDR_BUSCTL) || (a == `PGC_ADDR_PWR) ||
			(a == `PGC_ADDR_STATUS);
	end
endfunction

// places a power class in the self-id power field, all other bits zero
function [31:0] sid_mask;
	input [2:0] cls;
	begin
		sid_mask = 32'h0;
		sid_mask[`PGC_SID_PWR_MSB:`PGC_SID_PWR_LSB] = cls;
	end
endfunction

assign wr_fire   = aw_held && w_held && !s_axi_bvalid_o;
assign wr_busctl = wr_fire && (aw_addr == `PGC_ADDR_BUSCTL) && w_strb[0];
assign wr_pwr    = wr_fire && (aw_addr == `PGC_ADDR_PWR) && w_strb[0];
// only writes with the request bit set count; anything else is ignored
assign ibr_write = wr_busctl && w_data[`PGC_IBR_BIT]; // R12

// ----------------------------------------------------------------
// write channel: address and data taken in either order
// ----------------------------------------------------------------
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		aw_held         <= 1'b0;
		w_held          <= 1'b0;
		aw_addr         <= 4'h0;
		w_data          <= 32'h0;
		w_strb          <= 4'h0;
		s_axi_awready_o <= 1'b0;
		s_axi_wready_o  <= 1'b0;
		s_axi_bvalid_o  <= 1'b0;
		s_axi_bresp_o   <= `PGC_RESP_OKAY;
	end else begin
		s_axi_awready_o <= !aw_held && !s_axi_awready_o && !s_axi_bvalid_o;
		s_axi_wready_o  <= !w_held && !s_axi_wready_o && !s_axi_bvalid_o;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
		end
		if (wr_fire) begin
			aw_held        <= 1'b0;
			w_held         <= 1'b0;
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= is_mapped(aw_addr) ? `PGC_RESP_OKAY :
				`PGC_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// bus control: request bit, root holdoff, gap count
// ----------------------------------------------------------------
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		bus_reset_req_o    <= 1'b0;
		gap_count_o        <= `PGC_GAP_RESET;
		root_holdoff_bit_o <= 1'b0;
		gap_armed          <= 1'b0;
	end else begin
		bus_reset_req_o <= ibr_write; // R05
		if (ibr_write) begin
			gap_count_o        <= w_data[`PGC_GAP_MSB:`PGC_GAP_LSB]; // R06
			root_holdoff_bit_o <= w_data[`PGC_RHB_BIT]; // R06
			// the reset this write starts must not undo the new value
			gap_armed          <= 1'b0; // R09
		end else if (cfg_pkt_valid_i) begin
			gap_count_o        <= cfg_pkt_gap_i; // R07
			root_holdoff_bit_o <= cfg_pkt_rhb_i; // R07
			gap_armed          <= 1'b0; // R08
		end else if (bus_reset_done_i) begin
			if (gap_armed)
				gap_count_o <= `PGC_GAP_MAX; // R08
			gap_armed <= 1'b1; // R08
		end
	end
end

// ----------------------------------------------------------------
// power class: strap once after reset release, then software
// ----------------------------------------------------------------
always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		strap_pending      <= 1'b1;
		power_class_o      <= 3'h0;
		self_id_pwr_mask_o <= 32'h0;
	end else begin
		strap_pending <= 1'b0; // R13
		if (strap_pending) begin
			power_class_o <= power_class_straps_i; // R01
			self_id_pwr_mask_o <= sid_mask(power_class_straps_i); // R01
		end else if (wr_pwr) begin
			power_class_o <= w_data[`PGC_PWR_MSB:`PGC_PWR_LSB]; // R02
			self_id_pwr_mask_o <=
				sid_mask(w_data[`PGC_PWR_MSB:`PGC_PWR_LSB]); // R02
		end
	end
end

// ----------------------------------------------------------------
// read channel
// ----------------------------------------------------------------
always @* begin
	next_rdata = 32'h0;
	next_rresp = `PGC_RESP_OKAY;
	case (s_axi_araddr_i)
	`PGC_ADDR_BUSCTL: begin
		next_rdata[`PGC_GAP_MSB:`PGC_GAP_LSB] = gap_count_o; // R07
		next_rdata[`PGC_RHB_BIT] = root_holdoff_bit_o;
	end
	`PGC_ADDR_PWR: begin
		next_rdata[`PGC_PWR_MSB:`PGC_PWR_LSB] = power_class_o;
	end
	`PGC_ADDR_STATUS: begin
		next_rdata[`PGC_ST_ARMED_BIT] = gap_armed;
		// the reserved code is not counted as a bus-powered class
		next_rdata[`PGC_ST_BUSPWR_BIT] = power_class_o[`PGC_PWR_MSB] &&
			(power_class_o != `PGC_PWR_RESERVED); // R03 R04
		next_rdata[`PGC_ST_RSVD_BIT] =
			(power_class_o == `PGC_PWR_RESERVED); // R04
	end
	default: begin
		next_rresp = `PGC_RESP_SLVERR;
	end
	endcase
end

always @(posedge clock_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		s_axi_arready_o <= 1'b0;
		s_axi_rvalid_o  <= 1'b0;
		s_axi_rdata_o   <= 32'h0;
		s_axi_rresp_o   <= `PGC_RESP_OKAY;
	end else begin
		s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o;
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= next_rdata;
			s_axi_rresp_o  <= next_rresp;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end
end

endmodule // pgc_ctrl
`default_nettype wire

// file: test/pgc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module pgc_props (
	input wire logic	clock_i,
	input wire logic	rst_n_i,
	input wire logic [2:0]	power_class_straps_i,
	input wire logic	bus_reset_done_i,
	input wire logic	cfg_pkt_valid_i,
	input wire logic	cfg_pkt_rhb_i,
	input wire logic [5:0]	cfg_pkt_gap_i,
	input wire logic	s_axi_bvalid_o,
	input wire logic	bus_reset_req_o,
	input wire logic [5:0]	gap_count_o,
	input wire logic	root_holdoff_bit_o,
	input wire logic [2:0]	power_class_o,
	input wire logic [31:0]	self_id_pwr_mask_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// any write response clears arm: conservative, never arms too early
	logic arm;
	logic bv_q;
	always @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i) bv_q <= 1'h0;
		else bv_q <= s_axi_bvalid_o;
	always @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i) arm <= 1'h0;
		else if (cfg_pkt_valid_i || (s_axi_bvalid_o && !bv_q)) arm <= 1'h0;
		else if (bus_reset_done_i) arm <= 1'h1;
	a_strap_take: assert property ($rose(rst_n_i) |=>
		power_class_o == $past(power_class_straps_i)) else $error("strap");
	a_class_hold: assert property ($changed(power_class_o) |->
		!$past(rst_n_i, 2) || $rose(s_axi_bvalid_o)) else $error("class");
	a_mask_field: assert property ($stable(power_class_o) |->
		self_id_pwr_mask_o == {8'h00, power_class_o, 21'h0}) else $error("mask");
	a_req_pulse: assert property (bus_reset_req_o |=>
		!bus_reset_req_o [*2]) else $error("pulse");
	a_req_cause: assert property ($rose(bus_reset_req_o) |->
		s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("cause");
	a_cfg_load: assert property (cfg_pkt_valid_i |=>
		$rose(s_axi_bvalid_o) ||
		root_holdoff_bit_o == $past(cfg_pkt_rhb_i) &&
		gap_count_o == $past(cfg_pkt_gap_i)) else $error("packet");
	a_gap_force: assert property (arm && bus_reset_done_i
		&& !cfg_pkt_valid_i && !$rose(s_axi_bvalid_o)
		|=> $rose(s_axi_bvalid_o) || gap_count_o == 6'h3F) else $error("force");
	a_gap_cause: assert property ($changed(gap_count_o) |->
		$rose(s_axi_bvalid_o) || $past(cfg_pkt_valid_i) ||
		$past(bus_reset_done_i)) else $error("gap");
	c_req: cover property (bus_reset_req_o);
	c_force: cover property (arm && bus_reset_done_i);
	c_cfg: cover property (cfg_pkt_valid_i);
endmodule // pgc_props
bind pgc_ctrl pgc_props i_props (.*);
`default_nettype wire

// file: test/pgc_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgc_phy_model (
	input wire logic	clock_i,
	input wire logic	req_i,
	input wire logic [3:0]	lag_i,
	input wire logic	tx_i,
	input wire logic [6:0]	pkt_i,
	output var logic	done_o = '0,
	output var logic	cfg_o = '0,
	output var logic [6:0]	pkt_o = '0
);
	logic [4:0] cnt = '0;
	// a reset lasts a random span; packet fields are junk between packets
	always @(posedge clock_i) begin
		cnt <= req_i ? lag_i + 5'h2 : cnt - 5'(cnt != 5'h0);
		done_o <= cnt == 5'h1;
		cfg_o <= tx_i;
		pkt_o <= tx_i ? pkt_i : ~pkt_o;
	end
endmodule // pgc_phy_model
`default_nettype wire

// file: test/test_pgc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_pgc_ctrl;
	logic		clock_i = '0, rst_n_i = '0, awv = '0, wv = '0, arv = '0;
	logic		tx = '0, nodej = '0;
	logic [2:0]	straps = '0;
	logic [3:0]	aw_a = '0, ar_a = '0, lag = '0;
	logic [6:0]	pkt = '0;
	logic [31:0]	w_d = '0, v, got;
	logic [1:0]	resp;
	wire		aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, req, root_holdoff_bit, done, cfg;
	wire [1:0]	b_resp, r_resp;
	wire [5:0]	gap;
	wire [2:0]	pc;
	wire [6:0]	cpkt;
	wire [31:0]	r_data, mask;
	int		fail_count = 0, checks_done = 0, nreq = 0, want = 0;
	int		g = 63, h = 0, p = 0, arm = 0;
	pgc_ctrl i_dut (.clock_i, .rst_n_i, .power_class_straps_i(straps),
		.bus_reset_done_i(done), .cfg_pkt_valid_i(cfg),
		.cfg_pkt_rhb_i(cpkt[6]), .cfg_pkt_gap_i(cpkt[5:0]),
		.s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_rdy),
		.s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_vld),
		.s_axi_bready_i(1'h1), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
		.s_axi_rvalid_o(r_vld), .s_axi_rready_i(1'h1), .bus_reset_req_o(req),
		.gap_count_o(gap), .root_holdoff_bit_o(root_holdoff_bit), .power_class_o(pc),
		.self_id_pwr_mask_o(mask));
	pgc_phy_model i_phy (.clock_i, .req_i(req | nodej), .lag_i(lag),
		.tx_i(tx), .pkt_i(pkt), .done_o(done), .cfg_o(cfg), .pkt_o(cpkt));
	always #2 clock_i = ~clock_i;
	always @(posedge clock_i) nreq <= nreq + req;
	always @(posedge clock_i) lag <= 4'($urandom);
	task automatic cmp(input logic [31:0] got_v, input logic [31:0] exp_v);
		checks_done++;
		if (got_v !== exp_v) begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got_v, exp_v);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		aw_a <= a;
		w_d <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		do begin
			@(posedge clock_i);
			if (aw_rdy) awv <= 1'h0;
			if (w_rdy) wv <= 1'h0;
		end while (!b_vld);
		cmp(b_resp, 32'h0);
	endtask
	task automatic rd(input logic [3:0] a);
		ar_a <= a;
		arv <= 1'h1;
		do @(posedge clock_i); while (!ar_rdy);
		arv <= 1'h0;
		do @(posedge clock_i); while (!r_vld);
		got = r_data;
		resp = r_resp;
	endtask
	task automatic st;
		cmp({root_holdoff_bit, gap, pc}, h << 9 | g << 3 | p);
		cmp(mask, p << 21);
		rd(4'h0);
		cmp(got, h << 6 | g);
		rd(4'h8);
		cmp(got, (p == 5) << 2 | (p == 4 || p > 5) << 1 | arm);
	endtask
	// the partner ends any reset well inside this span
	task automatic brst;
		repeat (24) @(posedge clock_i);
		if (arm) g = 63;
		arm = 1;
	endtask
	// a bus reset started at the far side, as when a node joins
	task automatic jn;
		nodej <= 1'h1;
		@(posedge clock_i);
		nodej <= 1'h0;
		brst;
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hB5F15F98));
		straps <= 3'($urandom);
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'h1;
		@(posedge clock_i);
		p = straps;
		straps <= ~straps;
		repeat (3) @(posedge clock_i);
		st;
		for (int c = 0; c < 8; c++) begin
			wr(4'h4, c);
			p = c;
			st;
		end
		$display("power class test over");
		for (int c = 0; c < 6; c++) begin
			v = $urandom;
			pkt <= v[6:0];
			tx <= 1'h1;
			@(posedge clock_i);
			tx <= 1'h0;
			repeat (3) @(posedge clock_i);
			h = v[6];
			g = v[5:0];
			arm = 0;
			st;
			// a join before the follow-up reset leaves the gap count armed
			if (c % 2 == 1) begin
				jn;
				st;
			end
			rd(4'h0);
			wr(4'h0, got | 32'h80);
			want++;
			arm = 0;
			brst;
			st;
			if (c % 2 == 0) begin
				jn;
			end else begin
				wr(4'h0, h << 6 | 32'hBF);
				want++;
				g = 63;
				arm = 0;
				brst;
			end
			st;
		end
		$display("bus reset test over");
		rd(4'hC);
		cmp(resp, 32'h2);
		cmp(got, 32'h0);
		cmp(nreq, want);
		test_done;
	end
	initial begin
		#40us;
		fail_count++;
		test_done;
	end
endmodule // test_pgc_ctrl
`default_nettype wire
